// ===== logic/ubg_pkg.sv
// Shared constants, types and decoders of the serial transceiver block.
package ubg_pkg;

	// ==========================================================
	// Register byte offsets on the AXI4-Lite bus
	localparam logic [7:0] OFS_DATA = 8'h00;
	localparam logic [7:0] OFS_CTRLA = 8'h04;
	localparam logic [7:0] OFS_CTRLB = 8'h08;
	localparam logic [7:0] OFS_CTRLC = 8'h0c;
	localparam logic [7:0] OFS_BAUDLO = 8'h10;
	localparam logic [7:0] OFS_BAUDHI = 8'h14;

	// ==========================================================
	// Field positions of ctrl_status_a
	localparam int A_DBL = 0;
	localparam int A_TXDONE = 1;
	localparam int A_EMPTY = 2;
	localparam int A_RXRDY = 3;
	localparam int A_FE = 4;
	localparam int A_DOR = 5;
	localparam int A_PE = 6;

	// Field positions of the enable register
	localparam int B_TXEN = 0;
	localparam int B_RXEN = 1;
	localparam int B_IETX = 2;
	localparam int B_IEEMP = 3;
	localparam int B_IERX = 4;
	localparam int B_SIZE = 5;

	// Field positions of ctrl_status_c
	localparam int C_SYNC = 0;
	localparam int C_XDIR = 1;
	localparam int C_POL = 2;
	localparam int C_PEN = 3;
	localparam int C_PODD = 4;
	localparam int C_STOP2 = 5;

	// ==========================================================
	// Reset values and widths
	localparam int BAUD_W = 12;
	localparam int BAUD_LO_W = 8;
	localparam logic [2:0] RST_SIZE = 3'h3;
	localparam logic [BAUD_W-1:0] RST_BAUD = 12'h000;

	// ==========================================================
	// Baud tick counts: bit period minus one, and majority sample point
	localparam logic [3:0] PRE_NORM = 4'hf;
	localparam logic [3:0] PRE_DBL = 4'h7;
	localparam logic [3:0] MID_NORM = 4'h9;
	localparam logic [3:0] MID_DBL = 4'h5;

	// Bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// ==========================================================
	// Frame and clocking configuration carried as one word.
	typedef struct packed {
		logic sync;
		logic xdir;
		logic pol;
		logic parEn;
		logic parOdd;
		logic stop2;
		logic dbl;
		logic [2:0] size;
	} ubg_cfg_t;

	// One receive buffer entry with its error marks.
	typedef struct packed {
		logic fe;
		logic pe;
		logic [8:0] data;
	} ubg_rxent_t;

	// ==========================================================
	// Character size code 0..4 gives 5..9 data bits; others give 8.
	function automatic logic [3:0] ubg_bits(input logic [2:0] code);
		// Widened first: a three-bit sum would wrap for codes 3 and 4.
		ubg_bits = (code > 3'h4) ? 4'h8 : {1'b0, code} + 4'h5;
	endfunction : ubg_bits

	// Address decode shared by the write and read answers.
	function automatic logic ubg_mapped(input logic [7:0] a);
		ubg_mapped = (a == OFS_DATA) || (a == OFS_CTRLA) ||
			(a == OFS_CTRLB) || (a == OFS_CTRLC) ||
			(a == OFS_BAUDLO) || (a == OFS_BAUDHI);
	endfunction : ubg_mapped

endpackage : ubg_pkg

// ===== logic/ubg_baud_gen.sv
// Baud rate down-counter that emits one tick per divisor plus one clocks.
module ubg_baud_gen #(
	parameter int W = 12
) (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Divisor and reload request
	input wire logic [W-1:0] divisor,
	input wire logic reload,
	// Tick output
	output logic tick
);

	logic [W-1:0] cnt;

	// ==========================================================
	// Tick when the count is at zero; a reload restarts the period.
	assign tick = (cnt == '0) & ~reload;

	// Count down every clock, reload at zero or on request.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt <= '0;
		end else if (reload || cnt == '0) begin
			cnt <= divisor;
		end else begin
			cnt <= cnt - 1'b1;
		end
	end

endmodule : ubg_baud_gen

// ===== logic/ubg_usart.sv
// Serial transceiver with baud generator, four clock modes and bus slave.
// What this block does
// - Four modes: normal, double, master, slave.
// - Sync select one means synchronous operation.
// - Double speed acts only in asynchronous mode.
// - Pin direction picks master or slave clock.
// - Transfer clock pin idle in asynchronous modes.
// - Down-counter reloads at zero or low write.
// - Tick each zero: clock over divisor plus one.
// - Transmit bit clock: ticks over 2/8/16.
// - Receiver uses ticks with 2/8/16 states.
// - Bit rate: clock over 16/8/2 times.
// - Twelve-bit divisor from high and low parts.
// - One transmit buffer allows gapless frames.
// - Receive buffer holds two characters.
// - Flags frame, overrun and parity errors.
// - Frames of 5-9 data, 1-2 stop bits.
// - Hardware odd or even parity both ways.
// - Majority filter; false start bits dropped.
// - Three requests: sent, buffer empty, received.
// - Transmit and receive run independently.
// - External clock synchronised before use.
// - Recovery bypassed for synchronous reception.
// - Slave clock: sync, edge detect, below quarter.
// - Polarity chooses change and sample edges.
// - Double speed: divider 8, eight samples.
//
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
module ubg_usart import ubg_pkg::*; (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// AXI4-Lite write channels
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read channels
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Serial lines
	output logic txd,
	input wire logic rxd,
	input wire logic xckIn,
	output logic xckOut,
	output logic xckOe_n,
	// Event requests
	output logic txDoneIrq,
	output logic dataEmptyIrq,
	output logic rxDoneIrq
);

	typedef enum logic [2:0] {TX_IDLE, TX_DATA, TX_PAR, TX_STOP,
		TX_LAST} ubg_txst_t;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR,
		RX_STOP} ubg_rxst_t;

	ubg_cfg_t cfg;
	logic [BAUD_W-1:0] baud;
	logic baudReload, txEn, rxEn, ieTx, ieEmp, ieRx;
	logic [7:0] awAddr;
	logic [31:0] wData;
	logic [3:0] wStrb;

	// ==========================================================
	// Bus decode
	wire awTake = awvalid & awready;
	wire wTake = wvalid & wready;
	wire arTake = arvalid & arready;
	wire doWrite = ~awready & ~wready & ~bvalid;
	wire wLo = doWrite & wStrb[0];
	wire wrData = wLo & (awAddr == OFS_DATA);
	wire wrCtrlA = wLo & (awAddr == OFS_CTRLA);
	wire wrCtrlB = wLo & (awAddr == OFS_CTRLB);
	wire wrCtrlC = wLo & (awAddr == OFS_CTRLC);
	wire wrBaudLo = wLo & (awAddr == OFS_BAUDLO);
	wire wrBaudHi = wLo & (awAddr == OFS_BAUDHI);
	wire rdPop;
	logic [31:0] statA, statB, statC, rdMux;

	// ==========================================================
	// Bus slave: address and data taken in either order, then answer.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			awready <= 1'b1;
			wready <= 1'b1;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h0;
			rresp <= RESP_OKAY;
			awAddr <= 8'h00;
			wData <= 32'h0;
			wStrb <= 4'h0;
		end else begin
			if (awTake) begin
				awAddr <= awaddr;
				awready <= 1'b0;
			end
			if (wTake) begin
				wData <= wdata;
				wStrb <= wstrb;
				wready <= 1'b0;
			end
			if (doWrite) begin
				bvalid <= 1'b1;
				bresp <= ubg_mapped(awAddr) ? RESP_OKAY : RESP_DECERR;
			end
			if (bvalid && bready) begin
				bvalid <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
			if (arTake) begin
				arready <= 1'b0;
				rvalid <= 1'b1;
				rdata <= rdMux;
				rresp <= ubg_mapped(araddr) ? RESP_OKAY : RESP_DECERR;
			end
			if (rvalid && rready) begin
				rvalid <= 1'b0;
				arready <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Configuration registers; a low divisor write restarts the count.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cfg <= '{size: RST_SIZE, default: 1'b0};
			baud <= RST_BAUD;
			baudReload <= 1'b0;
			{txEn, rxEn, ieTx, ieEmp, ieRx} <= 5'h00;
		end else begin
			baudReload <= wrBaudLo;
			if (wrCtrlA) cfg.dbl <= wData[A_DBL];
			if (wrCtrlB) begin
				txEn <= wData[B_TXEN];
				rxEn <= wData[B_RXEN];
				ieTx <= wData[B_IETX];
				ieEmp <= wData[B_IEEMP];
				ieRx <= wData[B_IERX];
				cfg.size <= wData[B_SIZE+:3];
			end
			if (wrCtrlC) begin
				cfg.sync <= wData[C_SYNC];
				cfg.xdir <= wData[C_XDIR];
				cfg.pol <= wData[C_POL];
				cfg.parEn <= wData[C_PEN];
				cfg.parOdd <= wData[C_PODD];
				cfg.stop2 <= wData[C_STOP2];
			end
			if (wrBaudLo) baud[BAUD_LO_W-1:0] <= wData[BAUD_LO_W-1:0];
			if (wrBaudHi) begin
				baud[BAUD_W-1:BAUD_LO_W] <= wData[BAUD_W-BAUD_LO_W-1:0];
			end
		end
	end

	// ==========================================================
	// Clock generation: baud ticks, mode decode, pin edges.
	wire bTick;
	ubg_baud_gen #(.W(BAUD_W)) u_baud (
		.clk(sys_clk),
		.arst_n(arst_n),
		.divisor(baud),
		.reload(baudReload),
		.tick(bTick)
	);

	// The speed bit is masked in sync mode, so a stale setting is harmless.
	wire dblEff = cfg.dbl & ~cfg.sync;
	wire master = cfg.sync & cfg.xdir;
	wire slave = cfg.sync & ~cfg.xdir;
	wire [3:0] preTop = dblEff ? PRE_DBL : PRE_NORM;
	wire [3:0] midTop = dblEff ? MID_DBL : MID_NORM;
	logic xcM, xcS, xcP;
	logic [3:0] pre;

	// Pin edges; the slave path sees xcS and xcP only, never xcM.
	wire mRise = master & bTick & ~xckOut;
	wire mFall = master & bTick & xckOut;
	wire sRise = slave & xcS & ~xcP;
	wire sFall = slave & ~xcS & xcP;
	wire xRise = mRise | sRise;
	wire xFall = mFall | sFall;
	wire syncChg = cfg.pol ? xFall : xRise;
	wire syncSmp = cfg.pol ? xRise : xFall;
	wire asyncStrb = ~cfg.sync & bTick & (pre == preTop);
	wire txStrb = cfg.sync ? syncChg : asyncStrb;

	// Synchroniser, prescaler and pin drive. The master clock toggles
	// each tick, so one bit lasts two ticks.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			{xcM, xcS, xcP} <= 3'h0;
			pre <= 4'h0;
			xckOut <= 1'b0;
			xckOe_n <= 1'b1;
		end else begin
			xcM <= xckIn;
			xcS <= xcM;
			xcP <= xcS;
			if (bTick) pre <= (pre == preTop) ? 4'h0 : pre + 4'h1;
			xckOe_n <= ~master;
			if (!master || !(txEn || rxEn)) xckOut <= 1'b0;
			else if (bTick) xckOut <= ~xckOut;
		end
	end

	// ==========================================================
	// Transmitter: one buffer ahead of the shift register.
	ubg_txst_t txSt;
	logic [8:0] txBuf, txSh;
	logic txFull, txPar, txDone;
	logic [3:0] txCnt;
	wire [3:0] nBits = ubg_bits(cfg.size);
	wire [8:0] bitMask = 9'h1ff >> (4'h9 - nBits);
	wire txLoad = txEn & txStrb & txFull &
		((txSt == TX_IDLE) | (txSt == TX_LAST));
	wire txEnd = txStrb & (txSt == TX_LAST) & ~txLoad;

	// Buffer fill; a write while full is dropped.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			txBuf <= 9'h000;
			txFull <= 1'b0;
		end else if (txLoad) begin
			txFull <= 1'b0;
		end else if (wrData && !txFull) begin
			txBuf <= {wStrb[1] & wData[8], wData[7:0]};
			txFull <= 1'b1;
		end
	end

	// Frame sequencer; each strobe starts the next bit on the line.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			txSt <= TX_IDLE;
			txSh <= 9'h000;
			txCnt <= 4'h0;
			txPar <= 1'b0;
			txd <= 1'b1;
		end else if (!txEn) begin
			txSt <= TX_IDLE;
			txd <= 1'b1;
		end else if (txLoad) begin
			txd <= 1'b0;
			txSh <= txBuf & bitMask;
			txPar <= ^(txBuf & bitMask) ^ cfg.parOdd;
			txCnt <= 4'h0;
			txSt <= TX_DATA;
		end else if (txStrb) begin
			case (txSt)
				TX_DATA: begin
					txd <= txSh[0];
					txSh <= txSh >> 1;
					txCnt <= txCnt + 4'h1;
					if (txCnt == nBits - 4'h1) begin
						txSt <= cfg.parEn ? TX_PAR : TX_STOP;
						txCnt <= 4'h0;
					end
				end
				TX_PAR: begin
					txd <= txPar;
					txSt <= TX_STOP;
				end
				TX_STOP: begin
					txd <= 1'b1;
					txCnt <= 4'h1;
					if (!cfg.stop2 || txCnt != 4'h0) txSt <= TX_LAST;
				end
				TX_LAST: txSt <= TX_IDLE;
				default: txSt <= TX_IDLE;
			endcase
		end
	end

	// Completion flag: the hardware set wins over a same-cycle clear.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) txDone <= 1'b0;
		else if (txEnd) txDone <= 1'b1;
		else if (wrCtrlA && wData[A_TXDONE]) txDone <= 1'b0;
	end

	// ==========================================================
	// Receiver: own synchroniser, recovery and two-entry buffer.
	ubg_rxst_t rxSt;
	ubg_rxent_t rb [0:1];
	logic rxM, rxS, rxPbit, dor, wrP, rdP;
	logic [1:0] smp, rxCnt;
	logic [3:0] sc, rxBitCnt;
	logic [8:0] rsh;

	// Three-sample majority rejects short glitches around mid-bit.
	wire maj = (smp[1] & smp[0]) | (smp[1] & rxS) | (smp[0] & rxS);
	wire rxBit = cfg.sync ? syncSmp : (bTick & (sc == midTop));
	wire bitVal = cfg.sync ? rxS : maj;
	wire [8:0] rxAligned = rsh >> (4'h9 - nBits);
	wire rxPe = cfg.parEn & (^rxAligned ^ cfg.parOdd ^ rxPbit);
	wire push = rxBit & (rxSt == RX_STOP);
	wire full2 = (rxCnt == 2'h2);
	assign rdPop = arTake & (araddr == OFS_DATA) & (rxCnt != 2'h0);

	// Receive state machine, independent of the transmitter.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			{rxM, rxS} <= 2'h3;
			smp <= 2'h3;
			sc <= 4'h0;
			rxSt <= RX_IDLE;
			rsh <= 9'h000;
			rxBitCnt <= 4'h0;
			rxPbit <= 1'b0;
		end else begin
			rxM <= rxd;
			rxS <= rxM;
			if (bTick) smp <= {smp[0], rxS};
			if (bTick && rxSt != RX_IDLE) begin
				sc <= (sc == preTop) ? 4'h0 : sc + 4'h1;
			end
			if (!rxEn) begin
				rxSt <= RX_IDLE;
			end else case (rxSt)
				RX_IDLE: begin
					rsh <= 9'h000;
					rxBitCnt <= 4'h0;
					sc <= 4'h1;
					if (cfg.sync && syncSmp && !rxS) rxSt <= RX_DATA;
					else if (!cfg.sync && bTick && !rxS) rxSt <= RX_START;
				end
				RX_START: if (rxBit) begin
					rxSt <= bitVal ? RX_IDLE : RX_DATA;
				end
				RX_DATA: if (rxBit) begin
					rsh <= {bitVal, rsh[8:1]};
					rxBitCnt <= rxBitCnt + 4'h1;
					if (rxBitCnt == nBits - 4'h1) begin
						rxSt <= cfg.parEn ? RX_PAR : RX_STOP;
					end
				end
				RX_PAR: if (rxBit) begin
					rxPbit <= bitVal;
					rxSt <= RX_STOP;
				end
				RX_STOP: if (rxBit) rxSt <= RX_IDLE;
				default: rxSt <= RX_IDLE;
			endcase
		end
	end

	// Two-entry buffer; a character arriving when both are full is lost.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rb[0] <= '0;
			rb[1] <= '0;
			wrP <= 1'b0;
			rdP <= 1'b0;
			rxCnt <= 2'h0;
			dor <= 1'b0;
		end else begin
			if (push && !full2) begin
				rb[wrP] <= '{fe: ~bitVal, pe: rxPe, data: rxAligned};
				wrP <= ~wrP;
			end
			if (rdPop) rdP <= ~rdP;
			rxCnt <= rxCnt + 2'((push && !full2) ? 1 : 0) -
				2'(rdPop ? 1 : 0);
			if (push && full2) dor <= 1'b1;
			else if (rdPop) dor <= 1'b0;
		end
	end

	// ==========================================================
	// Read data and requests.
	always_comb begin
		statA = 32'h0;
		statA[A_DBL] = cfg.dbl;
		statA[A_TXDONE] = txDone;
		statA[A_EMPTY] = ~txFull;
		statA[A_RXRDY] = (rxCnt != 2'h0);
		statA[A_FE] = rb[rdP].fe & (rxCnt != 2'h0);
		statA[A_DOR] = dor;
		statA[A_PE] = rb[rdP].pe & (rxCnt != 2'h0);
		statB = 32'h0;
		statB[B_TXEN] = txEn;
		statB[B_RXEN] = rxEn;
		statB[B_IETX] = ieTx;
		statB[B_IEEMP] = ieEmp;
		statB[B_IERX] = ieRx;
		statB[B_SIZE+:3] = cfg.size;
		statC = 32'h0;
		statC[C_SYNC] = cfg.sync;
		statC[C_XDIR] = cfg.xdir;
		statC[C_POL] = cfg.pol;
		statC[C_PEN] = cfg.parEn;
		statC[C_PODD] = cfg.parOdd;
		statC[C_STOP2] = cfg.stop2;
		case (araddr)
			OFS_DATA: rdMux = {23'h0, rb[rdP].data};
			OFS_CTRLA: rdMux = statA;
			OFS_CTRLB: rdMux = statB;
			OFS_CTRLC: rdMux = statC;
			OFS_BAUDLO: rdMux = {24'h0, baud[BAUD_LO_W-1:0]};
			OFS_BAUDHI: rdMux = {28'h0, baud[BAUD_W-1:BAUD_LO_W]};
			default: rdMux = 32'h0;
		endcase
	end

	// Requests are level, gated by their enables, and follow flags by one.
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			{txDoneIrq, dataEmptyIrq, rxDoneIrq} <= 3'h0;
		end else begin
			txDoneIrq <= txDone & ieTx;
			dataEmptyIrq <= ~txFull & ieEmp;
			rxDoneIrq <= (rxCnt != 2'h0) & ieRx;
		end
	end

endmodule : ubg_usart

// ===== tb/ubg_serial_peer.sv
// Far-end serial device model that sends and times frames.
module ubg_serial_peer (
	// Clock
	input wire logic clk,
	// Serial lines
	input wire logic txd,
	output logic rxd
);
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================
	// Sending side
	// The line idles high between frames, as a pulled-up line would.
	initial rxd = 1'h1;

	// Start bit, data first bit lowest, optional parity, one stop bit.
	task automatic send_frame(input logic [8:0] d, input int bits,
			input int per, input logic pen, input logic pbit);
		int i;
		rxd <= 1'h0;
		repeat (per) @(posedge clk);
		for (i = 0; i < bits; i++) begin
			rxd <= d[i];
			repeat (per) @(posedge clk);
		end
		if (pen) begin
			rxd <= pbit;
			repeat (per) @(posedge clk);
		end
		rxd <= 1'h1;
		repeat (per) @(posedge clk);
	endtask : send_frame

	// ==========================================
	// Receiving side
	// Times the start bit exactly, then samples each bit in its middle.
	// The start length is exact only when the first data bit is one.
	task automatic grab_frame(input int bits, input int per,
			output logic [8:0] d, output int lowLen, output logic stp);
		int i;
		d = 9'h000;
		lowLen = 0;
		while (txd !== 1'h0) @(posedge clk);
		while (txd === 1'h0) begin
			@(posedge clk);
			lowLen++;
		end
		repeat (per / 2) @(posedge clk);
		for (i = 0; i < bits; i++) begin
			d[i] = txd;
			repeat (per) @(posedge clk);
		end
		stp = txd;
	endtask : grab_frame
endmodule : ubg_serial_peer

// ===== tb/ubg_usart_asserts.sv
// Bus handshake and transfer clock checks on the transceiver ports.
module ubg_usart_asserts (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Register bus handshakes
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic rvalid,
	input wire logic rready,
	// Transfer clock pin
	input wire logic xckOut,
	input wire logic xckOe_n
);
	// ==========================================
	// Bus answers
	// One clock domain, so clock and reset are given once here.
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	// A write taken on both channels is answered two edges later.
	property p_wr_answer;
		awvalid && awready && wvalid && wready |-> ##2 bvalid;
	endproperty
	a_wr_answer: assert property (p_wr_answer) else $error("write late");

	// A read address taken is answered at the next edge.
	property p_rd_answer;
		arvalid && arready |=> rvalid;
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read late");

	// Answers stand until the master takes them.
	property p_b_hold;
		bvalid && !bready |=> bvalid;
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");

	property p_r_hold;
		rvalid && !rready |=> rvalid && $stable(rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("rdata dropped");

	// No new request is taken while an answer is pending.
	property p_w_block;
		bvalid |-> !awready && !wready;
	endproperty
	a_w_block: assert property (p_w_block) else $error("write open");

	property p_r_block;
		rvalid |-> !arready;
	endproperty
	a_r_block: assert property (p_r_block) else $error("read open");

	// The channels reopen right after the answer is taken.
	property p_w_free;
		bvalid && bready |=> !bvalid && awready && wready;
	endproperty
	a_w_free: assert property (p_w_free) else $error("write stuck");

	property p_r_free;
		rvalid && rready |=> !rvalid && arready;
	endproperty
	a_r_free: assert property (p_r_free) else $error("read stuck");

	// ==========================================
	// Transfer clock pin
	// The pin stays quiet unless this end drives it as master.
	property p_xck_idle;
		xckOe_n && $past(xckOe_n) |-> !xckOut;
	endproperty
	a_xck_idle: assert property (p_xck_idle) else $error("xck on");

	property p_xck_master;
		$rose(xckOut) |-> !xckOe_n;
	endproperty
	a_xck_master: assert property (p_xck_master) else $error("no oe");
endmodule : ubg_usart_asserts

bind ubg_usart ubg_usart_asserts u_chk (
	.sys_clk, .arst_n, .awvalid, .awready, .wvalid, .wready, .bvalid,
	.bready, .arvalid, .arready, .rdata, .rvalid, .rready, .xckOut,
	.xckOe_n
);

// ===== tb/tb.sv
// Self-checking bench for the serial transceiver block.
module tb import ubg_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================
	// Signals and instances
	logic sys_clk = 1'h0;
	logic arst_n = 1'h0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
	logic arvalid = 1'h0, rready = 1'h0, xckIn = 1'h0;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0] wstrb = 4'h0;
	logic [1:0] bresp, rresp;
	logic awready, wready, bvalid, arready, rvalid, txd, rxd;
	logic xckOut, xckOe_n, txDoneIrq, dataEmptyIrq, rxDoneIrq;
	int miscompares = 0;
	int tests_run = 0;

	always #20 sys_clk = ~sys_clk;

	ubg_usart u_dut (
		.sys_clk, .arst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready, .txd, .rxd, .xckIn,
		.xckOut, .xckOe_n, .txDoneIrq, .dataEmptyIrq, .rxDoneIrq
	);

	ubg_serial_peer u_peer (.clk(sys_clk), .txd(txd), .rxd(rxd));

	// ==========================================
	// Shared tasks
	task automatic chk(input string s, input logic [31:0] e,
			input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", s, e, g);
			miscompares++;
		end
	endtask : chk

	// Ready is read just after the edge, so it is the value sampled there.
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
			input logic [1:0] er);
		int n;
		awaddr <= a;
		awvalid <= 1'h1;
		wdata <= d;
		wstrb <= 4'hf;
		wvalid <= 1'h1;
		// Response ready stays high, so back-to-back calls never clash.
		bready <= 1'h1;
		n = 0;
		do begin
			@(posedge sys_clk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
			n++;
		end while (!(bvalid && bready) && n < 100);
		chk("bvalid", 32'h1, {31'h0, bvalid});
		chk("bresp", {30'h0, er}, {30'h0, bresp});
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] m,
			input logic [31:0] e, input logic [1:0] er);
		int n;
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		n = 0;
		do begin
			@(posedge sys_clk);
			if (arready) arvalid <= 1'h0;
			n++;
		end while (!(rvalid && rready) && n < 100);
		chk("rvalid", 32'h1, {31'h0, rvalid});
		chk("rdata", e, rdata & m);
		chk("rresp", {30'h0, er}, {30'h0, rresp});
	endtask : rd

	// ==========================================
	// Scenarios
	task automatic t_reset();
		chk("txd_idle", 32'h1, {31'h0, txd});
		chk("xck_oe", 32'h1, {31'h0, xckOe_n});
		rd(OFS_CTRLB, 32'hff, 32'h60, RESP_OKAY);
		rd(OFS_CTRLC, 32'hff, 32'h00, RESP_OKAY);
		rd(8'h18, 32'hffffffff, 32'h0, RESP_DECERR);
		wr(8'h18, 32'hff, RESP_DECERR);
		wr(OFS_BAUDHI, 32'hff, RESP_OKAY);
		rd(OFS_BAUDHI, 32'hff, 32'h0f, RESP_OKAY);
		wr(OFS_BAUDHI, 32'h0, RESP_OKAY);
	endtask : t_reset

	// Divisor one, so a bit lasts two clocks times the mode divider.
	task automatic t_tx(input logic dbl, input logic [31:0] cfgc,
			input int bits, input logic [8:0] e);
		logic [8:0] d;
		int lowLen;
		logic stp;
		wr(OFS_BAUDLO, 32'h1, RESP_OKAY);
		wr(OFS_CTRLA, {30'h0, 1'h1, dbl}, RESP_OKAY);
		rd(OFS_CTRLA, 32'h02, 32'h00, RESP_OKAY);
		wr(OFS_CTRLC, cfgc, RESP_OKAY);
		wr(OFS_CTRLB, 32'h6d, RESP_OKAY);
		fork
			wr(OFS_DATA, 32'ha5, RESP_OKAY);
			u_peer.grab_frame(bits, dbl ? 16 : 32, d, lowLen, stp);
		join
		chk("start_len", dbl ? 32'h10 : 32'h20, lowLen);
		chk("tx_bits", {23'h0, e}, {23'h0, d});
		chk("tx_stop", 32'h1, {31'h0, stp});
		// Wait past the stop bit so the complete flag has been set.
		repeat (80) @(posedge sys_clk);
		rd(OFS_CTRLA, 32'h06, 32'h06, RESP_OKAY);
		chk("tx_irq", 32'h1, {31'h0, txDoneIrq});
		chk("empty_irq", 32'h1, {31'h0, dataEmptyIrq});
	endtask : t_tx

	// Three frames into a two-deep buffer: the third one overruns.
	task automatic t_rx();
		int i;
		wr(OFS_CTRLA, 32'h0, RESP_OKAY);
		wr(OFS_CTRLC, 32'h08, RESP_OKAY);
		wr(OFS_CTRLB, 32'h72, RESP_OKAY);
		for (i = 0; i < 3; i++) begin
			u_peer.send_frame(9'h03c, 8, 32, 1'h1, i[0]);
		end
		repeat (4) @(posedge sys_clk);
		chk("rx_irq", 32'h1, {31'h0, rxDoneIrq});
		rd(OFS_CTRLA, 32'h68, 32'h28, RESP_OKAY);
		rd(OFS_DATA, 32'h1ff, 32'h3c, RESP_OKAY);
		rd(OFS_CTRLA, 32'h68, 32'h48, RESP_OKAY);
		rd(OFS_DATA, 32'h1ff, 32'h3c, RESP_OKAY);
		repeat (2) @(posedge sys_clk);
		chk("rx_irq_off", 32'h0, {31'h0, rxDoneIrq});
	endtask : t_rx

	// Master clock half period equals divisor plus one clocks.
	task automatic t_sync();
		int n;
		wr(OFS_BAUDLO, 32'h3, RESP_OKAY);
		wr(OFS_CTRLB, 32'h61, RESP_OKAY);
		wr(OFS_CTRLC, 32'h03, RESP_OKAY);
		repeat (3) @(posedge sys_clk);
		chk("oe_master", 32'h0, {31'h0, xckOe_n});
		// Find a true rising edge, so the high half is timed in full.
		n = 0;
		while (xckOut !== 1'h0 && n < 100) begin
			@(posedge sys_clk);
			n++;
		end
		while (xckOut !== 1'h1 && n < 100) begin
			@(posedge sys_clk);
			n++;
		end
		n = 0;
		while (xckOut === 1'h1 && n < 100) begin
			@(posedge sys_clk);
			n++;
		end
		chk("xck_half", 32'h4, n);
		wr(OFS_CTRLC, 32'h01, RESP_OKAY);
		repeat (3) @(posedge sys_clk);
		chk("oe_slave", 32'h1, {31'h0, xckOe_n});
		// Slave: each pin rise, three clocks late, shifts the next bit.
		wr(OFS_DATA, 32'h1, RESP_OKAY);
		for (n = 0; n < 2; n++) begin
			xckIn <= 1'h1;
			repeat (4) @(posedge sys_clk);
			chk("s_txd", {31'h0, n[0]}, {31'h0, txd});
			xckIn <= 1'h0;
			repeat (4) @(posedge sys_clk);
		end
		wr(OFS_CTRLC, 32'h00, RESP_OKAY);
		repeat (3) @(posedge sys_clk);
		chk("xck_async", 32'h0, {31'h0, xckOut});
	endtask : t_sync

	// ==========================================
	// Verdict, watchdog and main sequence
	task automatic summarize();
		if (miscompares == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : summarize

	// The tests need a few thousand clocks; this allows twenty thousand.
	initial begin
		#800000;
		miscompares++;
		summarize();
	end

	initial begin
		repeat (4) @(posedge sys_clk);
		arst_n <= 1'h1;
		@(posedge sys_clk);
		// No power-reduction gate exists, so the unit is live from reset.
		t_reset();
		t_tx(1'h0, 32'h00, 8, 9'h0a5);
		t_tx(1'h1, 32'h18, 9, 9'h1a5);
		t_rx();
		t_sync();
		summarize();
	end
endmodule : tb
